// ### design/field_mask_gen.sv
`timescale 1ns/10ps
`default_nettype none

module field_mask_gen (
	// Field position
	input  wire logic [4:0]  lsb_i,
	input  wire logic [5:0]  width_i,
	// Mask of width ones starting at lsb
	output logic      [31:0] mask_o
);

	// ==========================================================================
	// Mask
	// ==========================================================================
	// One extra bit lets a full 32-bit width come out as all ones.
	logic [32:0] ones;

	always_comb begin
		ones   = (33'h0_0000_0001 << width_i) - 33'h0_0000_0001;
		// Bits past the top are lost; the issuer keeps lsb plus width within the word.
		mask_o = ones[31:0] << lsb_i;
	end

endmodule

`default_nettype wire

// ### design/pack_extend_bitfield_unit.sv
// Function
// - Pack low: low first, shifted second high
// - Pack high: high first, arithmetic-shifted second low
// - Left shift 0-31; right shift zero means 32
// - Pack leaves condition flags untouched
// - Extends rotate source right by 0/8/16/24
// - Byte widen: bits 7..0, sign or zero
// - Half widen: bits 15..0, sign or zero
// - Dual widen: bytes 0 and 2 into halves
// - Add forms: add word or per halfword
// - Extend and field ops leave flags untouched
// - Field clear zeroes width bits at lsb
// - Field insert copies low source bits in
// - Signed extract sign-extends field top bit
// - Unsigned extract zero-fills above field
`timescale 1ns/10ps
`default_nettype none

module pack_extend_bitfield_unit (
	// Clock, reset, enable
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	// Operation
	input  wire logic                 op_valid_i,
	input  wire pebu_pkg::op_code_t   op_code_i,
	input  wire logic                 cond_pass_i,
	// Operands
	input  wire logic [31:0]          first_operand_i,
	input  wire logic [31:0]          second_operand_i,
	input  wire logic [31:0]          dest_old_i,
	// Immediates
	input  wire logic [4:0]           shift_amt_i,
	input  wire logic [1:0]           rot_sel_i,
	input  wire logic [4:0]           lsb_i,
	input  wire logic [5:0]           width_i,
	// Result
	output logic      [31:0]          result_o,
	output logic                      result_valid_o,
	output logic                      dest_write_o,
	output logic                      flags_write_o
);

	// ==========================================================================
	// Decode helpers
	// ==========================================================================
	function automatic logic op_signed(input pebu_pkg::op_code_t op);
		case (op)
			pebu_pkg::sign_widen_byte,
			pebu_pkg::sign_widen_half,
			pebu_pkg::sign_widen_dual_byte,
			pebu_pkg::sign_widen_byte_add,
			pebu_pkg::sign_widen_half_add,
			pebu_pkg::sign_widen_dual_byte_add: op_signed = 1'b1;
			default:                            op_signed = 1'b0;
		endcase
	endfunction

	function automatic logic op_adds(input pebu_pkg::op_code_t op);
		case (op)
			pebu_pkg::sign_widen_byte_add,
			pebu_pkg::zero_widen_byte_add,
			pebu_pkg::sign_widen_half_add,
			pebu_pkg::zero_widen_half_add,
			pebu_pkg::sign_widen_dual_byte_add,
			pebu_pkg::zero_widen_dual_byte_add: op_adds = 1'b1;
			default:                            op_adds = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] widen_byte(input logic [7:0] b, input logic sgn);
		widen_byte = {{8{sgn & b[7]}}, b};
	endfunction

	// ==========================================================================
	// Shared datapath
	// ==========================================================================
	logic        sgn;
	logic        adds;
	logic [63:0] rot_dbl;
	logic [31:0] rotated;
	logic [31:0] lsl_val;
	logic [5:0]  asr_amt;
	logic signed [31:0] asr_val;
	logic [31:0] widen_b;
	logic [31:0] widen_h;
	logic [31:0] widen_d;
	logic [31:0] sum_word_b;
	logic [31:0] sum_word_h;
	logic [31:0] sum_dual;
	logic [31:0] field_mask;
	logic [31:0] low_mask;
	logic [31:0] extract_raw;
	logic        field_top;
	logic [31:0] exec_value;

	always_comb begin
		sgn        = op_signed(op_code_i);
		adds       = op_adds(op_code_i);
		// Doubling the word turns the right rotation into a plain shift.
		rot_dbl    = {second_operand_i, second_operand_i} >> {rot_sel_i, 3'b000};
		rotated    = rot_dbl[31:0];
		lsl_val    = second_operand_i << shift_amt_i;
		asr_amt    = (shift_amt_i == 5'h00) ? pebu_pkg::ASR_FULL_SHIFT
		                                    : {1'b0, shift_amt_i};
		asr_val    = $signed(second_operand_i) >>> asr_amt;
		widen_b    = {{16{sgn & rotated[7]}}, widen_byte(rotated[7:0], sgn)};
		widen_h    = {{16{sgn & rotated[15]}}, rotated[15:0]};
		sum_word_b = first_operand_i + widen_b;
		sum_word_h = first_operand_i + widen_h;
	end

	// Each lane adds on its own, so a carry never crosses into the other halfword.
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane++) begin : g_lane
			assign widen_d[lane*16 +: 16]  = widen_byte(rotated[lane*16 +: 8], sgn);
			assign sum_dual[lane*16 +: 16] = first_operand_i[lane*16 +: 16]
			                               + widen_d[lane*16 +: 16];
		end
	endgenerate

	field_mask_gen u_field_mask (
		.lsb_i   (lsb_i),
		.width_i (width_i),
		.mask_o  (field_mask)
	);

	field_mask_gen u_low_mask (
		.lsb_i   (5'h00),
		.width_i (width_i),
		.mask_o  (low_mask)
	);

	always_comb begin
		extract_raw = first_operand_i >> lsb_i;
		field_top   = |(extract_raw & low_mask & ~(low_mask >> 1));
	end

	// ==========================================================================
	// Operation select
	// ==========================================================================
	always_comb begin
		case (op_code_i)
			pebu_pkg::pack_low_high:
				exec_value = {lsl_val[15:0], first_operand_i[15:0]};
			pebu_pkg::pack_high_low:
				exec_value = {first_operand_i[31:16], asr_val[15:0]};
			pebu_pkg::sign_widen_byte,
			pebu_pkg::zero_widen_byte:
				exec_value = widen_b;
			pebu_pkg::sign_widen_half,
			pebu_pkg::zero_widen_half:
				exec_value = widen_h;
			pebu_pkg::sign_widen_dual_byte,
			pebu_pkg::zero_widen_dual_byte:
				exec_value = widen_d;
			pebu_pkg::sign_widen_byte_add,
			pebu_pkg::zero_widen_byte_add:
				exec_value = sum_word_b;
			pebu_pkg::sign_widen_half_add,
			pebu_pkg::zero_widen_half_add:
				exec_value = sum_word_h;
			pebu_pkg::sign_widen_dual_byte_add,
			pebu_pkg::zero_widen_dual_byte_add:
				exec_value = sum_dual;
			pebu_pkg::field_clear:
				exec_value = dest_old_i & ~field_mask;
			pebu_pkg::field_insert:
				exec_value = (dest_old_i & ~field_mask)
				           | ((first_operand_i << lsb_i) & field_mask);
			pebu_pkg::signed_field_extract:
				exec_value = field_top ? (extract_raw | ~low_mask)
				                       : (extract_raw & low_mask);
			pebu_pkg::unsigned_field_extract:
				exec_value = extract_raw & low_mask;
			default:
				exec_value = dest_old_i;
		endcase
	end

	// ==========================================================================
	// Result register
	// ==========================================================================
	logic [31:0] result;
	logic        result_valid;
	logic        dest_write;
	logic        flags_write;
	logic [31:0] next_result;
	logic        next_result_valid;
	logic        next_dest_write;
	logic        next_flags_write;

	always_comb begin
		next_result       = result;
		next_result_valid = 1'b0;
		next_dest_write   = 1'b0;
		// Nothing here has a path to the flags, so the strobe stays low.
		next_flags_write  = pebu_pkg::FLAGS_WRITE;
		if (op_valid_i && (op_code_i != pebu_pkg::op_none)) begin
			next_result_valid = 1'b1;
			// A failed condition leaves both the destination and the held result alone.
			if (cond_pass_i) begin
				next_dest_write = 1'b1;
				next_result     = exec_value;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result       <= pebu_pkg::RESULT_RESET;
			result_valid <= pebu_pkg::VALID_RESET;
			dest_write   <= pebu_pkg::WRITE_RESET;
			flags_write  <= pebu_pkg::FLAGS_WRITE;
		end else if (ce_i) begin
			result       <= next_result;
			result_valid <= next_result_valid;
			dest_write   <= next_dest_write;
			flags_write  <= next_flags_write;
		end
	end

	assign result_o       = result;
	assign result_valid_o = result_valid;
	assign dest_write_o   = dest_write;
	assign flags_write_o  = flags_write;

	// ==========================================================================
	// Checks
	// ==========================================================================
	logic        take;
	logic [15:0] chk_lsl_lo;
	logic [15:0] chk_asr_lo;
	logic [7:0]  chk_rot_byte;
	logic [31:0] chk_field;

	always_comb begin
		take         = ce_i && op_valid_i && cond_pass_i;
		chk_lsl_lo   = second_operand_i[15:0] << shift_amt_i;
		chk_asr_lo   = (shift_amt_i == 5'h00) ? {16{second_operand_i[31]}} : asr_val[15:0];
		case (rot_sel_i)
			2'h1:    chk_rot_byte = second_operand_i[15:8];
			2'h2:    chk_rot_byte = second_operand_i[23:16];
			2'h3:    chk_rot_byte = second_operand_i[31:24];
			default: chk_rot_byte = second_operand_i[7:0];
		endcase
		chk_field    = (first_operand_i & field_mask) >> lsb_i;
	end

	a_pack_low_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::pack_low_high |=>
		result_o == {$past(chk_lsl_lo), $past(first_operand_i[15:0])})
		else $error("pack low/high result wrong");

	a_pack_high_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::pack_high_low |=>
		result_o[31:16] == $past(first_operand_i[31:16]))
		else $error("pack high/low top half wrong");

	a_asr_zero_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::pack_high_low |=>
		result_o[15:0] == $past(chk_asr_lo))
		else $error("pack arithmetic shift amount wrong");

	a_flags_never: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		result_valid_o |-> !flags_write_o ##1 !flags_write_o)
		else $error("flags written by this unit");

	a_rotate_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::zero_widen_byte |=>
		result_o == {24'h00_0000, $past(chk_rot_byte)})
		else $error("rotated byte zero widen wrong");

	a_sign_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::sign_widen_byte |=>
		result_o[31:8] == {24{result_o[7]}})
		else $error("signed byte widen not replicated");

	a_half_widen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::zero_widen_half && rot_sel_i == 2'h0 |=>
		result_o == {16'h0000, $past(second_operand_i[15:0])})
		else $error("zero half widen wrong");

	a_dual_lanes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::sign_widen_dual_byte |=>
		result_o[15:8] == {8{result_o[7]}} && result_o[31:24] == {8{result_o[23]}})
		else $error("dual byte lanes not sign filled");

	a_add_word: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::zero_widen_byte_add |=>
		result_o == $past(first_operand_i) + {24'h00_0000, $past(chk_rot_byte)})
		else $error("byte widen add sum wrong");

	a_field_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::field_clear |=>
		(result_o & $past(field_mask)) == 32'h0000_0000
		&& (result_o & ~$past(field_mask)) == ($past(dest_old_i) & ~$past(field_mask)))
		else $error("field clear wrong");

	a_field_insert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::field_insert |=>
		((result_o & $past(field_mask)) >> $past(lsb_i)) == ($past(first_operand_i) & $past(low_mask)))
		else $error("field insert wrong");

	a_unsigned_extract: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::unsigned_field_extract |=>
		result_o == $past(chk_field))
		else $error("unsigned extract wrong");

	a_signed_extract: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		take && op_code_i == pebu_pkg::signed_field_extract |=>
		(result_o & $past(low_mask)) == $past(chk_field)
		&& (result_o & ~$past(low_mask)) == ($past(field_top) ? ~$past(low_mask) : 32'h0000_0000))
		else $error("signed extract wrong");

	a_cond_fail_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && op_valid_i && !cond_pass_i && op_code_i != pebu_pkg::op_none |=>
		result_valid_o && !dest_write_o && $stable(result_o))
		else $error("failed condition still wrote");

endmodule

`default_nettype wire

// ### design/pebu_pkg.sv
`default_nettype none

package pebu_pkg;

	// ==========================================================================
	// Widths and constants
	// ==========================================================================
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned HALF_W   = 16;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned SHIFT_W  = 5;
	localparam int unsigned WIDTH_W  = 6;
	localparam int unsigned ROT_W    = 2;

	// Rotation select shifted left by this many bits gives the rotation amount.
	localparam int unsigned ROT_UNIT_LOG2 = 3;

	// A zero shift field for the right-shifting pack means a full-word shift.
	localparam logic [WIDTH_W-1:0] ASR_FULL_SHIFT = 6'h20;

	// Reset values of the registered outputs.
	localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
	localparam logic              VALID_RESET  = 1'h0;
	localparam logic              WRITE_RESET  = 1'h0;
	localparam logic              FLAGS_WRITE  = 1'h0;

	// Cycles from an accepted operation to its result.
	localparam int unsigned LATENCY = 1;

	// ==========================================================================
	// Operation codes
	// ==========================================================================
	typedef enum logic [4:0] {
		op_none                  = 5'b00000,
		pack_low_high            = 5'b00001,
		pack_high_low            = 5'b00010,
		sign_widen_byte          = 5'b00011,
		zero_widen_byte          = 5'b00100,
		sign_widen_half          = 5'b00101,
		zero_widen_half          = 5'b00110,
		sign_widen_dual_byte     = 5'b00111,
		zero_widen_dual_byte     = 5'b01000,
		sign_widen_byte_add      = 5'b01001,
		zero_widen_byte_add      = 5'b01010,
		sign_widen_half_add      = 5'b01011,
		zero_widen_half_add      = 5'b01100,
		sign_widen_dual_byte_add = 5'b01101,
		zero_widen_dual_byte_add = 5'b01110,
		field_clear              = 5'b01111,
		field_insert             = 5'b10000,
		signed_field_extract     = 5'b10001,
		unsigned_field_extract   = 5'b10010
	} op_code_t;

endpackage

`default_nettype wire

// ### verif/dest_reg_model.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Destination register of the issuing core
// ============================================================================
// Only one general register is held, so stack pointer and counter never appear.
module dest_reg_model (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Preload from the bench
	input  wire logic        load_i,
	input  wire logic [31:0] load_val_i,
	// Write-back from the unit
	input  wire logic        dest_write_i,
	input  wire logic [31:0] result_i,
	// Current contents
	output logic      [31:0] dest_old_o
);
	// Without a load or a write strobe the register must keep its value.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dest_old_o <= 32'h0000_0000;
		end else if (load_i) begin
			dest_old_o <= load_val_i;
		end else if (dest_write_i) begin
			dest_old_o <= result_i;
		end
	end
endmodule

`default_nettype wire

// ### verif/pack_extend_bitfield_unit_test.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Bench top
// ============================================================================
module pack_extend_bitfield_unit_test;
	logic               sys_clk_i;
	logic               rst_i;
	logic               ce_i;
	logic               op_valid_i;
	pebu_pkg::op_code_t op_code_i;
	logic               cond_pass_i;
	logic [31:0]        first_operand_i;
	logic [31:0]        second_operand_i;
	logic [31:0]        dest_old;
	logic [4:0]         shift_amt_i;
	logic [1:0]         rot_sel_i;
	logic [4:0]         lsb_i;
	logic [5:0]         width_i;
	logic [31:0]        result_o;
	logic               result_valid_o;
	logic               dest_write_o;
	logic               flags_write_o;
	logic               load;
	logic [31:0]        load_val;
	int                 num_errors = 0;
	int                 compares = 0;
	pebu_pkg::op_code_t ext_ops [6] = '{pebu_pkg::sign_widen_byte, pebu_pkg::zero_widen_byte,
		pebu_pkg::sign_widen_half, pebu_pkg::zero_widen_half,
		pebu_pkg::sign_widen_dual_byte, pebu_pkg::zero_widen_dual_byte};
	pebu_pkg::op_code_t add_ops [6] = '{pebu_pkg::sign_widen_byte_add,
		pebu_pkg::zero_widen_byte_add, pebu_pkg::sign_widen_half_add,
		pebu_pkg::zero_widen_half_add, pebu_pkg::sign_widen_dual_byte_add,
		pebu_pkg::zero_widen_dual_byte_add};

	pack_extend_bitfield_unit pack_extend_bitfield_unit_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
		.op_code_i(op_code_i), .cond_pass_i(cond_pass_i), .first_operand_i(first_operand_i),
		.second_operand_i(second_operand_i), .dest_old_i(dest_old), .shift_amt_i(shift_amt_i),
		.rot_sel_i(rot_sel_i), .lsb_i(lsb_i), .width_i(width_i), .result_o(result_o),
		.result_valid_o(result_valid_o), .dest_write_o(dest_write_o),
		.flags_write_o(flags_write_o));

	dest_reg_model dest_reg_model_i (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(load), .load_val_i(load_val),
		.dest_write_i(dest_write_o), .result_i(result_o), .dest_old_o(dest_old));

	always #50 sys_clk_i = ~sys_clk_i;

	// ========================================================================
	// Shared tasks
	// ========================================================================
	task automatic give_verdict();
		if (num_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic preload(input logic [31:0] v);
		@(posedge sys_clk_i);
		load <= 1'b1;
		load_val <= v;
		@(posedge sys_clk_i);
		load <= 1'b0;
	endtask

	// The result lands one enabled edge after the request is taken.
	task automatic issue(input pebu_pkg::op_code_t code, input logic [31:0] a,
		input logic [31:0] b, input logic [4:0] sh, input logic [1:0] rot,
		input logic [4:0] lsb, input logic [5:0] wid, input logic cond);
		@(posedge sys_clk_i);
		op_code_i <= code;
		first_operand_i <= a;
		second_operand_i <= b;
		shift_amt_i <= sh;
		rot_sel_i <= rot;
		lsb_i <= lsb;
		width_i <= wid;
		cond_pass_i <= cond;
		op_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		op_valid_i <= 1'b0;
		#1;
		check({31'h0, flags_write_o}, 32'h0);
		check({31'h0, dest_write_o}, {31'h0, cond & ce_i});
	endtask

	function automatic logic [31:0] widen(input int k, input logic [31:0] s,
		input logic [1:0] rot);
		logic [63:0] d;
		logic [31:0] r;
		d = {s, s} >> (8 * rot);
		r = d[31:0];
		case (k)
			0: widen = {{24{r[7]}}, r[7:0]};
			1: widen = {24'h0, r[7:0]};
			2: widen = {{16{r[15]}}, r[15:0]};
			3: widen = {16'h0, r[15:0]};
			4: widen = {{8{r[23]}}, r[23:16], {8{r[7]}}, r[7:0]};
			default: widen = {8'h0, r[23:16], 8'h0, r[7:0]};
		endcase
	endfunction

	// ========================================================================
	// Scenarios
	// ========================================================================
	task automatic test_pack();
		issue(pebu_pkg::pack_low_high, 32'h1111_2222, 32'hA5C3_A5C3, 5'h00, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'hA5C3_2222);
		issue(pebu_pkg::pack_low_high, 32'h7777_8888, 32'h0123_0123, 5'h04, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'h1230_8888);
		issue(pebu_pkg::pack_low_high, 32'hFFFF_0001, 32'hFFFF_FFFE, 5'h1F, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'h0000_0001);
		issue(pebu_pkg::pack_high_low, 32'hABCD_1234, 32'h8765_4321, 5'h01, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'hABCD_A190);
		issue(pebu_pkg::pack_high_low, 32'hABCD_1234, 32'h8001_2345, 5'h10, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'hABCD_8001);
		issue(pebu_pkg::pack_high_low, 32'hABCD_1234, 32'h8000_0000, 5'h00, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'hABCD_FFFF);
		issue(pebu_pkg::pack_high_low, 32'hABCD_1234, 32'h7FFF_FFFF, 5'h00, 2'h0, 5'h00, 6'h01, 1'b1);
		check(result_o, 32'hABCD_0000);
	endtask

	// Bytes of mixed sign, and a base whose low lane overflows on any add.
	task automatic test_widen();
		logic [31:0] e;
		for (int k = 0; k < 6; k++) begin
			for (int r = 0; r < 4; r++) begin
				e = widen(k, 32'h12F0_7F81, 2'(r));
				issue(ext_ops[k], 32'h0, 32'h12F0_7F81, 5'h00, 2'(r), 5'h00, 6'h01, 1'b1);
				check(result_o, e);
				issue(add_ops[k], 32'h0001_FFFF, 32'h12F0_7F81, 5'h00, 2'(r), 5'h00, 6'h01, 1'b1);
				if (k >= 4) begin
					check(result_o, {16'h0001 + e[31:16], 16'hFFFF + e[15:0]});
				end else begin
					check(result_o, 32'h0001_FFFF + e);
				end
			end
		end
	endtask

	// Every field below keeps lsb within 0..31 and width within 1..32-lsb.
	task automatic test_fields();
		preload(32'hFFFF_FFFF);
		issue(pebu_pkg::field_clear, 32'h0, 32'h0, 5'h00, 2'h0, 5'h08, 6'h0C, 1'b1);
		check(result_o, 32'hFFF0_00FF);
		preload(32'h1234_5678);
		issue(pebu_pkg::field_insert, 32'hFFFF_FABC, 32'h0, 5'h00, 2'h0, 5'h08, 6'h0C, 1'b1);
		check(result_o, 32'h123A_BC78);
		preload(32'h0000_0000);
		issue(pebu_pkg::field_insert, 32'hDEAD_BEEF, 32'h0, 5'h00, 2'h0, 5'h00, 6'h20, 1'b1);
		check(result_o, 32'hDEAD_BEEF);
		preload(32'h0000_0000);
		issue(pebu_pkg::field_insert, 32'h0000_0001, 32'h0, 5'h00, 2'h0, 5'h1F, 6'h01, 1'b1);
		check(result_o, 32'h8000_0000);
		issue(pebu_pkg::signed_field_extract, 32'h0087_0000, 32'h0, 5'h00, 2'h0, 5'h14, 6'h04, 1'b1);
		check(result_o, 32'hFFFF_FFF8);
		issue(pebu_pkg::signed_field_extract, 32'hFF7F_FFFF, 32'h0, 5'h00, 2'h0, 5'h14, 6'h04, 1'b1);
		check(result_o, 32'h0000_0007);
		issue(pebu_pkg::signed_field_extract, 32'h8000_0000, 32'h0, 5'h00, 2'h0, 5'h1F, 6'h01, 1'b1);
		check(result_o, 32'hFFFF_FFFF);
		issue(pebu_pkg::unsigned_field_extract, 32'hFFFF_FFFF, 32'h0, 5'h00, 2'h0, 5'h09, 6'h0A, 1'b1);
		check(result_o, 32'h0000_03FF);
		issue(pebu_pkg::unsigned_field_extract, 32'h8000_0000, 32'h0, 5'h00, 2'h0, 5'h00, 6'h20, 1'b1);
		check(result_o, 32'h8000_0000);
	endtask

	task automatic test_cond_and_enable();
		issue(pebu_pkg::zero_widen_byte, 32'h0, 32'h0000_0042, 5'h00, 2'h0, 5'h00, 6'h01, 1'b1);
		issue(pebu_pkg::field_clear, 32'h0, 32'h0, 5'h00, 2'h0, 5'h00, 6'h08, 1'b0);
		check(result_o, 32'h0000_0042);
		check({31'h0, result_valid_o}, 32'h1);
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		issue(pebu_pkg::zero_widen_byte, 32'h0, 32'h0000_00FF, 5'h00, 2'h0, 5'h00, 6'h01, 1'b1);
		check({31'h0, result_valid_o}, 32'h0);
		check(result_o, 32'h0000_0042);
		check(dest_old, 32'h0000_0042);
		@(posedge sys_clk_i);
		ce_i <= 1'b1;
	endtask

	// ========================================================================
	// Main sequence
	// ========================================================================
	initial begin
		sys_clk_i = 1'b0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		op_valid_i = 1'b0;
		op_code_i = pebu_pkg::op_none;
		cond_pass_i = 1'b1;
		first_operand_i = 32'h0;
		second_operand_i = 32'h0;
		shift_amt_i = 5'h00;
		rot_sel_i = 2'h0;
		lsb_i = 5'h00;
		width_i = 6'h01;
		load = 1'b0;
		load_val = 32'h0;
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1;
		check(result_o, 32'h0);
		check({29'h0, result_valid_o, dest_write_o, flags_write_o}, 32'h0);
		test_pack();
		test_widen();
		test_fields();
		test_cond_and_enable();
		give_verdict();
	end

	// A hang is cut short well before the run could grow long.
	initial begin
		#2000000;
		num_errors++;
		give_verdict();
	end
endmodule

`default_nettype wire
